// ===== hdl/eap_port.sv
// Purpose: audio port pins: bit clocks, flag 0, shared data pin, gpio fallback
// Assumes: bit clock pins are fed back as rx_bit_clk / tx_bit_clk clock ports
// Notes: change sync_mode_select only while lanes are stopped; the receive lane clock is muxed
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module eap_port #(
  parameter int WORD_BITS = 24,
  parameter int SLOTS = 2
) (
  input wire logic pclk, // apb clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_bit_clk, // receive bit clock wire as a clock
  input wire logic tx_bit_clk, // transmit bit clock wire as a clock
  input wire logic rx_clk_pin_in, // receive clock pin level
  output eap_pkg::eap_pin_drv_s rx_clk_pin, // receive clock pin drive
  input wire logic tx_clk_pin_in, // transmit clock pin level
  output eap_pkg::eap_pin_drv_s tx_clk_pin, // transmit clock pin drive
  input wire logic data_pin_in, // shared data pin level
  output eap_pkg::eap_pin_drv_s data_pin // shared data pin drive
);
  localparam int W = WORD_BITS;

  typedef struct packed {
    logic sync_mode_select;
    logic network_mode;
    logic output_flag_zero;
    logic port_enable;
    logic tx_enable;
    logic rx_enable;
    logic rx_clock_direction_bit;
    logic tx_clock_direction;
    logic [7:0] half_period;
    eap_pkg::eap_gpio_mode_e [eap_pkg::NPINS-1:0] gp_mode;
    logic [eap_pkg::NPINS-1:0] gp_out;
    logic tx_run;
    logic rx_run;
    logic [W-1:0] tx_word;
    logic tx_req;
    logic ack_s1;
    logic ack_s2;
    logic tx_empty;
    logic rxt_s1;
    logic rxt_s2;
    logic rxt_seen;
    logic [W-1:0] rx_data;
    logic rx_full;
    logic if_s1;
    logic if_s2;
    logic [eap_pkg::NPINS-1:0] gpi_s1;
    logic [eap_pkg::NPINS-1:0] gpi_s2;
    logic [7:0] div_cnt;
    logic clk_q;
    eap_pkg::eap_pin_drv_s rxclk_drv;
    eap_pkg::eap_pin_drv_s txclk_drv;
    eap_pkg::eap_pin_drv_s data_drv;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } eap_port_s;

  eap_port_s q;
  eap_port_s next_q;
  logic rx_lane_clk;
  logic tx_serial_out;
  logic tx_ack;
  logic tx_flag_drive;
  logic [W-1:0] rx_word;
  logic rx_tgl;
  logic rx_flag_cap;

  // true for every offset the register map answers
  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == eap_pkg::ADDR_CTRL) begin
      hit = 1'b1;
    end else if (a == eap_pkg::ADDR_CLKCTRL) begin
      hit = 1'b1;
    end else if (a == eap_pkg::ADDR_STATUS) begin
      hit = 1'b1;
    end else if (a == eap_pkg::ADDR_TXDATA) begin
      hit = 1'b1;
    end else if (a == eap_pkg::ADDR_RXDATA) begin
      hit = 1'b1;
    end else if (a == eap_pkg::ADDR_GPCFG) begin
      hit = 1'b1;
    end else if (a == eap_pkg::ADDR_GPIN) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : is_mapped

  // register read mux; unmapped and write-only words read zero
  function automatic logic [31:0] read_word(input logic [7:0] a, input eap_port_s s);
    logic [31:0] d;
    d = eap_pkg::RD_ZERO;
    if (a == eap_pkg::ADDR_CTRL) begin
      d[eap_pkg::CTRL_SYNC] = s.sync_mode_select;
      d[eap_pkg::CTRL_NET] = s.network_mode;
      d[eap_pkg::CTRL_OF0] = s.output_flag_zero;
      d[eap_pkg::CTRL_PORT_EN] = s.port_enable;
      d[eap_pkg::CTRL_TX_EN] = s.tx_enable;
      d[eap_pkg::CTRL_RX_EN] = s.rx_enable;
    end else if (a == eap_pkg::ADDR_CLKCTRL) begin
      d[eap_pkg::CLK_RX_DIR] = s.rx_clock_direction_bit;
      d[eap_pkg::CLK_TX_DIR] = s.tx_clock_direction;
      d[eap_pkg::CLK_DIV_LSB +: 8] = s.half_period;
    end else if (a == eap_pkg::ADDR_STATUS) begin
      d[eap_pkg::ST_IF0] = s.if_s2;
      d[eap_pkg::ST_TX_EMPTY] = s.tx_empty;
      d[eap_pkg::ST_RX_FULL] = s.rx_full;
    end else if (a == eap_pkg::ADDR_RXDATA) begin
      d[W-1:0] = s.rx_data;
    end else if (a == eap_pkg::ADDR_GPCFG) begin
      for (int i = 0; i < eap_pkg::NPINS; i++) begin
        d[2*i +: 2] = s.gp_mode[i];
        d[eap_pkg::GPCFG_OUT_LSB + i] = s.gp_out[i];
      end
    end else if (a == eap_pkg::ADDR_GPIN) begin
      for (int i = 0; i < eap_pkg::NPINS; i++) begin
        d[i] = s.gpi_s2[i] & (s.gp_mode[i] == eap_pkg::EAP_GP_IN);
      end
    end
    return d;
  endfunction : read_word

  // receivers follow the transmit clock in sync mode
  assign rx_lane_clk = q.sync_mode_select ? tx_bit_clk : rx_bit_clk;

  // transmitter zero lane, also times output flag 0
  eap_lane #(
    .WIDTH(W),
    .SLOTS(SLOTS)
  ) u_tx_lane (
    .clk(tx_bit_clk),
    .rst_n(presetn),
    .en_in(q.tx_run),
    .net_in(q.network_mode),
    .flag_src(q.output_flag_zero),
    .word_req_tgl(q.tx_req),
    .tx_word(q.tx_word),
    .serial_in(1'b0),
    .flag_pin(1'b0),
    .serial_out(tx_serial_out),
    .word_ack_tgl(tx_ack),
    .rx_word(),
    .rx_tgl(),
    .flag_drive(tx_flag_drive),
    .flag_cap()
  );

  // receiver zero lane, also captures input flag 0
  eap_lane #(
    .WIDTH(W),
    .SLOTS(SLOTS)
  ) u_rx_lane (
    .clk(rx_lane_clk),
    .rst_n(presetn),
    .en_in(q.rx_run),
    .net_in(q.network_mode),
    .flag_src(1'b0),
    .word_req_tgl(1'b0),
    .tx_word('0),
    .serial_in(data_pin_in),
    .flag_pin(rx_clk_pin_in),
    .serial_out(),
    .word_ack_tgl(),
    .rx_word(rx_word),
    .rx_tgl(rx_tgl),
    .flag_drive(),
    .flag_cap(rx_flag_cap)
  );

  // bus slave, crossings, divider and pin drive state
  always_comb begin
    next_q = q;
    // two-flop synchronisers
    next_q.ack_s1 = tx_ack;
    next_q.ack_s2 = q.ack_s1;
    next_q.rxt_s1 = rx_tgl;
    next_q.rxt_s2 = q.rxt_s1;
    next_q.if_s1 = rx_flag_cap;
    next_q.if_s2 = q.if_s1;
    next_q.gpi_s1 = {data_pin_in, tx_clk_pin_in, rx_clk_pin_in};
    next_q.gpi_s2 = q.gpi_s1;
    // apb: one wait state, answer valid while pready is high
    next_q.pready = psel & penable & ~q.pready;
    next_q.pslverr = 1'b0; // error stands only with ready
    if (psel & penable & ~q.pready) begin
      next_q.prdata = read_word(paddr, q);
      next_q.pslverr = ~is_mapped(paddr);
    end
    if (psel & penable & q.pready & pwrite) begin
      if (paddr == eap_pkg::ADDR_CTRL) begin
        next_q.sync_mode_select = pwdata[eap_pkg::CTRL_SYNC];
        next_q.network_mode = pwdata[eap_pkg::CTRL_NET];
        next_q.output_flag_zero = pwdata[eap_pkg::CTRL_OF0];
        next_q.port_enable = pwdata[eap_pkg::CTRL_PORT_EN];
        next_q.tx_enable = pwdata[eap_pkg::CTRL_TX_EN];
        next_q.rx_enable = pwdata[eap_pkg::CTRL_RX_EN];
      end else if (paddr == eap_pkg::ADDR_CLKCTRL) begin
        next_q.rx_clock_direction_bit = pwdata[eap_pkg::CLK_RX_DIR];
        next_q.tx_clock_direction = pwdata[eap_pkg::CLK_TX_DIR];
        next_q.half_period = pwdata[eap_pkg::CLK_DIV_LSB +: 8];
      end else if (paddr == eap_pkg::ADDR_TXDATA) begin
        // a word already waiting is not overwritten
        if (q.tx_empty) begin
          next_q.tx_word = pwdata[W-1:0];
          next_q.tx_req = ~q.tx_req;
        end
      end else if (paddr == eap_pkg::ADDR_GPCFG) begin
        for (int i = 0; i < eap_pkg::NPINS; i++) begin
          next_q.gp_mode[i] = eap_pkg::eap_gpio_mode_e'(pwdata[2*i +: 2]);
          next_q.gp_out[i] = pwdata[eap_pkg::GPCFG_OUT_LSB + i];
        end
      end
    end
    // reading the receive word clears rx_full
    if (psel & penable & q.pready & ~pwrite & (paddr == eap_pkg::ADDR_RXDATA)) begin
      next_q.rx_full = 1'b0;
    end
    // a new received word sets rx_full, winning over the clear
    if (q.rxt_s2 != q.rxt_seen) begin
      next_q.rxt_seen = q.rxt_s2;
      next_q.rx_data = rx_word;
      next_q.rx_full = 1'b1;
    end
    next_q.tx_empty = (q.ack_s2 == next_q.tx_req);
    // each lane runs on its own enable in port mode; both run in sync mode for flag timing
    next_q.tx_run = q.port_enable & (q.tx_enable | q.sync_mode_select);
    next_q.rx_run = q.port_enable & (q.rx_enable | q.sync_mode_select);
    // bit clock divider for pins set as clock outputs
    if (q.div_cnt >= q.half_period) begin
      next_q.div_cnt = '0;
      next_q.clk_q = ~q.clk_q;
    end else begin
      next_q.div_cnt = q.div_cnt + 8'h01;
    end
    // pin drive: port function or gpio fallback
    if (q.port_enable) begin
      next_q.rxclk_drv.oe = q.rx_clock_direction_bit;
      next_q.rxclk_drv.o = q.clk_q;
      next_q.txclk_drv.oe = q.tx_clock_direction;
      next_q.txclk_drv.o = q.clk_q;
      next_q.data_drv.oe = q.tx_enable;
      next_q.data_drv.o = 1'b0;
    end else begin
      next_q.rxclk_drv.oe = (q.gp_mode[eap_pkg::PIN_RXCLK] == eap_pkg::EAP_GP_OUT);
      next_q.rxclk_drv.o = q.gp_out[eap_pkg::PIN_RXCLK];
      next_q.txclk_drv.oe = (q.gp_mode[eap_pkg::PIN_TXCLK] == eap_pkg::EAP_GP_OUT);
      next_q.txclk_drv.o = q.gp_out[eap_pkg::PIN_TXCLK];
      next_q.data_drv.oe = (q.gp_mode[eap_pkg::PIN_DATA] == eap_pkg::EAP_GP_OUT);
      next_q.data_drv.o = q.gp_out[eap_pkg::PIN_DATA];
    end
  end

  // state register; reset leaves gpio disconnected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.tx_empty <= 1'b1;
      q.half_period <= eap_pkg::DIV_RESET;
    end else begin
      q <= next_q;
    end
  end

  // outputs; flag 0 and serial data come from bit clock flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign rx_clk_pin.oe = q.rxclk_drv.oe;
  assign rx_clk_pin.o = (q.port_enable & q.sync_mode_select) ? tx_flag_drive : q.rxclk_drv.o;
  assign tx_clk_pin = q.txclk_drv;
  assign data_pin.oe = q.data_drv.oe;
  assign data_pin.o = q.port_enable ? tx_serial_out : q.data_drv.o;
endmodule : eap_port

// ===== hdl/eap_pkg.sv
// Purpose: shared constants and carriers for the audio port pin block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: gpio encodings follow eap_gpio_mode_e order
package eap_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLKCTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0c;
  localparam logic [7:0] ADDR_RXDATA = 8'h10;
  localparam logic [7:0] ADDR_GPCFG = 8'h14;
  localparam logic [7:0] ADDR_GPIN = 8'h18;
  // common_control_reg fields
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_NET = 1;
  localparam int CTRL_OF0 = 2;
  localparam int CTRL_PORT_EN = 3;
  localparam int CTRL_TX_EN = 4;
  localparam int CTRL_RX_EN = 5;
  // rx_clock_control_reg fields
  localparam int CLK_RX_DIR = 0;
  localparam int CLK_TX_DIR = 1;
  localparam int CLK_DIV_LSB = 8;
  // common_status_reg fields
  localparam int ST_IF0 = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_FULL = 2;
  // gpio config: two mode bits per pin, then output data bits
  localparam int GPCFG_OUT_LSB = 8;
  localparam int NPINS = 3;
  localparam int PIN_RXCLK = 0;
  localparam int PIN_TXCLK = 1;
  localparam int PIN_DATA = 2;
  // reset values
  localparam logic [7:0] DIV_RESET = 8'h03;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    EAP_GP_OFF,
    EAP_GP_IN,
    EAP_GP_OUT
  } eap_gpio_mode_e;

  typedef struct packed {
    logic o;
    logic oe;
  } eap_pin_drv_s;
endpackage : eap_pkg

// ===== hdl/eap_lane.sv
// Purpose: one serial lane on a bit clock: shifter, slot/frame counter, flag timing
// Assumes: clk is the serial bit clock; en_in, net_in, flag_src, word_req_tgl are from pclk
// Notes: msb first; a word loads at the first bit of the next slot
`timescale 1ns/1ns
module eap_lane #(
  parameter int WIDTH = 24,
  parameter int SLOTS = 2
) (
  input wire logic clk, // serial bit clock
  input wire logic rst_n, // async reset, active low
  input wire logic en_in, // lane run level, pclk domain
  input wire logic net_in, // network mode level, pclk domain
  input wire logic flag_src, // output flag value, pclk domain
  input wire logic word_req_tgl, // toggles when tx_word is new
  input wire logic [WIDTH-1:0] tx_word, // word to send, held while pending
  input wire logic serial_in, // serial data bit in
  input wire logic flag_pin, // flag pin level
  output logic serial_out, // serial data bit out
  output logic word_ack_tgl, // toggles when tx_word was taken
  output logic [WIDTH-1:0] rx_word, // last received word
  output logic rx_tgl, // toggles per received word
  output logic flag_drive, // flag value for the pin
  output logic flag_cap // captured flag pin level
);
  localparam int CW = $clog2(WIDTH);
  localparam int SW = (SLOTS > 1) ? $clog2(SLOTS) : 1;
  localparam logic [CW-1:0] LAST_BIT = CW'(WIDTH - 1);
  localparam logic [SW-1:0] LAST_SLOT = SW'(SLOTS - 1);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic net_s1;
    logic net_s2;
    logic of_s1;
    logic of_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [CW-1:0] bitcnt;
    logic [SW-1:0] slotcnt;
    logic [WIDTH-1:0] shreg;
    logic [WIDTH-1:0] hold;
    logic rx_tgl;
    logic flag_out;
    logic flag_s1;
    logic flag_s2;
    logic flag_in;
  } eap_lane_s;

  eap_lane_s q;
  eap_lane_s next_q;
  logic slot_end;
  logic frame_end;

  // slot and frame boundaries
  assign slot_end = (q.bitcnt == LAST_BIT);
  assign frame_end = slot_end && (q.slotcnt == LAST_SLOT);

  // shifting, word hand-off and flag timing
  always_comb begin
    next_q = q;
    next_q.en_s1 = en_in;
    next_q.en_s2 = q.en_s1;
    next_q.net_s1 = net_in;
    next_q.net_s2 = q.net_s1;
    next_q.of_s1 = flag_src;
    next_q.of_s2 = q.of_s1;
    next_q.req_s1 = word_req_tgl;
    next_q.req_s2 = q.req_s1;
    next_q.flag_s1 = flag_pin; // pin is async to the bit clock
    next_q.flag_s2 = q.flag_s1;
    if (!q.en_s2) begin
      next_q.bitcnt = '0;
      next_q.slotcnt = '0;
      next_q.shreg = '0;
    end else begin
      next_q.bitcnt = slot_end ? '0 : q.bitcnt + 1'b1;
      next_q.shreg = {q.shreg[WIDTH-2:0], serial_in};
      if (slot_end) begin
        next_q.slotcnt = frame_end ? '0 : q.slotcnt + 1'b1;
        next_q.hold = {q.shreg[WIDTH-2:0], serial_in};
        next_q.rx_tgl = ~q.rx_tgl;
        if (q.req_s2 != q.ack) begin
          next_q.shreg = tx_word;
          next_q.ack = ~q.ack;
        end
      end
      // flag moves on frame in normal mode, on slot in network mode
      if (q.net_s2 ? slot_end : frame_end) begin
        next_q.flag_out = q.of_s2;
        next_q.flag_in = q.flag_s2;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign serial_out = q.shreg[WIDTH-1];
  assign word_ack_tgl = q.ack;
  assign rx_word = q.hold;
  assign rx_tgl = q.rx_tgl;
  assign flag_drive = q.flag_out;
  assign flag_cap = q.flag_in;
endmodule : eap_lane

// ===== tb/eap_codec.sv
// Purpose: far-side codec model: bit clocks and serial data
// Assumes: 32 ns bit period on both clocks
// Notes: a stopped clock rests at idle_hi so it can act as a flag level
`timescale 1ns/1ns
module eap_codec (
  input wire logic rrun, // run receive clock
  input wire logic trun, // run transmit clock
  input wire logic idle_hi, // level of a stopped clock
  input wire logic dhi, // level sent on data
  output logic rclk, // receive bit clock
  output logic tclk, // transmit bit clock
  output logic sdata // serial data level
);
  // receive clock, phase offset from the transmit clock
  initial begin
    rclk = 1'b0;
    #7;
    forever #16 rclk = rrun ? ~rclk : idle_hi;
  end
  // transmit clock, stands still when stopped
  initial begin
    tclk = 1'b0;
    forever #16 tclk = trun ? ~tclk : idle_hi;
  end
  assign sdata = dhi; // steady data level
endmodule : eap_codec

// ===== tb/eap_port_props.sv
// Purpose: port checks for eap_port
// Assumes: one apb wait state, pin enables set by register writes
// Notes: all checks in the pclk domain
`timescale 1ns/1ns
module eap_port_chk (
  input wire logic pclk, // apb clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire eap_pkg::eap_pin_drv_s rx_clk_pin, // receive clock pin drive
  input wire eap_pkg::eap_pin_drv_s tx_clk_pin, // transmit clock pin drive
  input wire eap_pkg::eap_pin_drv_s data_pin // data pin drive
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  // completed transfers
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  property p_one_wait;
    s_setup |=> s_wait ##1 acc;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  property p_map_ok;
    acc && paddr <= eap_pkg::ADDR_GPIN && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_map_ok: assert property (p_map_ok) else $error("error on mapped address");
  property p_unmap;
    acc && paddr > eap_pkg::ADDR_GPIN |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("no error on unmapped address");
  property p_rst_off;
    $rose(presetn) |-> !rx_clk_pin.oe && !tx_clk_pin.oe && !data_pin.oe;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("pin driven after reset");
  property p_rx_oe;
    $changed(rx_clk_pin.oe) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_rx_oe: assert property (p_rx_oe) else $error("rx pin enable moved alone");
  property p_data_oe;
    $changed(data_pin.oe) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data pin enable moved alone");
endmodule : eap_port_chk
bind eap_port eap_port_chk eap_port_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .rx_clk_pin, .tx_clk_pin, .data_pin);

// ===== tb/eap_port_tb.sv
// Purpose: directed bench for eap_port
// Assumes: codec model drives bit clocks, pins pulled down
// Notes: word search tolerates unknown slot phase
`timescale 1ns/1ns
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module eap_port_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  eap_pkg::eap_pin_drv_s rx_clk_pin, tx_clk_pin, data_pin;
  logic rrun, trun, idle_hi, dhi, rdrv, tdrv, ddrv, rclk, tclk, sdata, rx_w, tx_w, d_w;
  logic [79:0] cap;
  int bad_count = 0, n_compared = 0, cyc = 0, hit;
  // pin wires, pulled down when nobody drives
  assign rx_w = rx_clk_pin.oe ? rx_clk_pin.o : (rdrv & rclk);
  assign tx_w = tx_clk_pin.oe ? tx_clk_pin.o : (tdrv & tclk);
  assign d_w = data_pin.oe ? data_pin.o : (ddrv & sdata);
  eap_port #(.WORD_BITS(24), .SLOTS(2)) eap_port_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_bit_clk(rx_w), .tx_bit_clk(tx_w),
    .rx_clk_pin_in(rx_w), .rx_clk_pin, .tx_clk_pin_in(tx_w), .tx_clk_pin, .data_pin_in(d_w), .data_pin);
  eap_codec eap_codec_inst (.rrun, .trun, .idle_hi, .dhi, .rclk, .tclk, .sdata);
  // register clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // one apb transfer, held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // sample the data wire once per bit
  task automatic grab();
    for (int i = 0; i < 80; i++) begin
      @(negedge tclk);
      cap = {cap[78:0], d_w};
    end
  endtask : grab
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rrun, trun, idle_hi, dhi, rdrv, tdrv, ddrv} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK({rx_clk_pin.oe, tx_clk_pin.oe, data_pin.oe}, 3'h0)
    xfer(0, eap_pkg::ADDR_CLKCTRL, 0);
    `CHK(rd, 32'h0000_0300)
    xfer(0, eap_pkg::ADDR_STATUS, 0);
    `CHK(rd, 32'h0000_0002)
    xfer(0, 8'h1c, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // gpio: rx pin out high, tx pin in, data off
    xfer(1, eap_pkg::ADDR_GPCFG, 32'h0000_0106);
    idle_hi <= 1'b1;
    tdrv <= 1'b1;
    repeat (4) @(negedge pclk);
    `CHK({rx_clk_pin.oe, rx_clk_pin.o, tx_clk_pin.oe, data_pin.oe}, 4'hc)
    xfer(0, eap_pkg::ADDR_GPIN, 0);
    `CHK(rd, 32'h0000_0002)
    xfer(1, eap_pkg::ADDR_GPCFG, 32'h0000_0228);
    repeat (4) @(negedge pclk);
    `CHK({rx_clk_pin.oe, data_pin.oe, data_pin.o, tx_clk_pin.oe, tx_clk_pin.o}, 5'h0b)
    xfer(1, eap_pkg::ADDR_GPCFG, 0);
    // async transmit
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_0018);
    trun <= 1'b1;
    xfer(1, eap_pkg::ADDR_TXDATA, 32'h00b4_e1c7);
    grab();
    `CHK(data_pin.oe, 1'b1)
    hit = 0;
    for (int i = 0; i <= 56; i++) if (cap[i +: 24] === 24'hb4e1c7) hit = 1;
    `CHK(hit, 1)
    xfer(1, eap_pkg::ADDR_CTRL, 0);
    {trun, ddrv, dhi, rdrv, rrun} <= 5'h0f;
    // async receive on the receive clock
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_0028);
    repeat (60) @(posedge rclk);
    xfer(0, eap_pkg::ADDR_STATUS, 0);
    `CHK(rd[2], 1'b1)
    xfer(0, eap_pkg::ADDR_RXDATA, 0);
    `CHK(rd, 32'h00ff_ffff)
    xfer(1, eap_pkg::ADDR_CTRL, 0);
    repeat (8) @(posedge rclk);
    xfer(0, eap_pkg::ADDR_RXDATA, 0);
    rrun <= 1'b0;
    xfer(0, eap_pkg::ADDR_STATUS, 0);
    `CHK(rd[2], 1'b0)
    // sync: receiver on transmit clock, rx pin is input flag
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_0001);
    trun <= 1'b1;
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_0029);
    repeat (60) @(posedge tclk);
    xfer(0, eap_pkg::ADDR_STATUS, 0);
    `CHK(rd[2:0], 3'h7)
    `CHK(rx_clk_pin.oe, 1'b0)
    idle_hi <= 1'b0;
    repeat (60) @(posedge tclk);
    xfer(0, eap_pkg::ADDR_STATUS, 0);
    `CHK(rd[0], 1'b0)
    // sync: rx pin as output flag, normal then network
    rdrv <= 1'b0;
    xfer(1, eap_pkg::ADDR_CLKCTRL, 32'h0000_0301);
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_002d);
    repeat (60) @(posedge tclk);
    @(negedge pclk);
    `CHK({rx_clk_pin.oe, rx_clk_pin.o}, 2'h3)
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_0029);
    repeat (60) @(posedge tclk);
    @(negedge pclk);
    `CHK({rx_clk_pin.oe, rx_clk_pin.o}, 2'h2)
    xfer(1, eap_pkg::ADDR_CTRL, 32'h0000_002f);
    repeat (30) @(posedge tclk);
    @(negedge pclk);
    `CHK(rx_clk_pin.o, 1'b1)
    final_report();
  end
endmodule : eap_port_tb
